// file: logic/wsr_pkg.sv
// Constants and state type of the warm and software reset sequencer
package wsr_pkg;
   // Clock 40 MHz, one cycle per clock half-period tick
   localparam int CLK_PERIOD_NS = 25;
   localparam int ARM_HALF      = 4;    // Least low time seen by the sequencer
   localparam int CANCEL_HALF   = 12;   // Window for cancel and abort
   localparam int SEQ_HALF      = 1024; // Internal sequence length
   localparam int SAMPLE_HALF   = 8;    // Delay to sampling the filtered input
   localparam int RELEASE_HALF  = 3;    // Transparency release delay
   localparam logic [10:0] ARM_CNT     = 11'(ARM_HALF);
   localparam logic [10:0] CANCEL_CNT  = 11'(CANCEL_HALF);
   localparam logic [10:0] SEQ_CNT     = 11'(SEQ_HALF);
   localparam logic [10:0] SAMPLE_CNT  = 11'(SAMPLE_HALF);
   localparam logic [10:0] RELEASE_CNT = 11'(RELEASE_HALF);
   localparam int SYNC_STAGES = 2;      // Depth of the pin synchronisers
   // Release count seen after the synchronisers, so the total stays 3 to 4
   localparam logic [1:0]  REL_MATCH   = 2'(RELEASE_HALF - SYNC_STAGES);
   localparam logic [10:0] CNT_ONE     = 11'h001;
   localparam logic [10:0] CNT_ZERO    = 11'h000;
   localparam logic [23:0] START_ADDR  = 24'h000000;
   localparam logic [15:0] CFG_RESET   = 16'hFFFF;
   localparam logic [15:0] SW_KEEP     = 16'h1F00; // Bits 12 to 8
   localparam logic [15:0] SW_ONES     = 16'h00FC; // Bits 7 to 2
   localparam int BDIR_BIT = 3;

   typedef enum logic [2:0] {
      WSR_RUN    = 3'b000,
      WSR_ARM    = 3'b001,
      WSR_CANCEL = 3'b010,
      WSR_SEQ    = 3'b011,
      WSR_SAMPLE = 3'b100,
      WSR_EXTEND = 3'b101,
      WSR_ASYNC  = 3'b110
   } wsr_state_t;
endpackage

// file: logic/wsr_sequencer.sv
// Warm hardware and software reset sequencer
// Function
// RQ1: Low reset input with sense pin high starts a synchronous reset.
// RQ2: Outside party holds reset input low at least four half-periods.
// RQ3: On synchronous reset, tristate I/O pins and drive reset output low.
// RQ4: Up to twelve half-periods cancel holds, finish access, abort bus cycle.
// RQ5: Pull reset pin down during reset only if bidirectional enable was set.
// RQ6: Bidirectional enable clears at power-on and at every sequence end.
// RQ7: Within sixteen half-periods, run an internal sequence of exactly 1024.
// RQ8: Eight half-periods after the sequence, sample filtered input: short or long.
// RQ9: Long reset makes configuration port bits 15 to 13 transparent too.
// RQ10: Those bits return opaque 3 to 4 half-periods after filtered input rises.
// RQ11: Bidirectional mode holds reset pin low through sequence, releases at end.
// RQ12: Extend reset until reset input high and, internal boot, flash ready.
// RQ13: On exit latch configuration and park address latch and strobes inactive.
// RQ14: Fetch restarts at address zero in code segment zero.
// RQ15: Weak pull-down on sense pin whenever reset input is low.
// RQ16: Sense pin low during hardware synchronous reset switches to asynchronous.
// RQ17: Asynchronous reset completes even if sense pin rises again.
// RQ18: Software or watchdog reset completes regardless of sense pin.
// RQ19: Filtered reset input qualifies sense pin status during reset.
// RQ20: Software reset instruction starts the sequence any time, as short reset. The code accepts it only in WSR_RUN and ignores it in WSR_ARM.
// RQ21: Software reset latches port bits 12 to 8, sets bits 7 to 2.
// RQ22: Software reset pulls reset pin low only when sense pin high.
module wsr_sequencer
   import wsr_pkg::*;
(
   // Clock and reset
   input  wire logic         clock_i,
   input  wire logic         rst_n_i,
   // Pins, asynchronous
   input  wire logic         reset_in_n_i,
   input  wire logic         filtered_reset_in_i,
   input  wire logic         reset_power_down_pin_i,
   input  wire logic         external_access_sel_i,
   input  wire logic [15:0]  config_port_i,
   // Core side
   input  wire logic         software_reset_instr_i,
   input  wire logic         bidir_reset_set_i,
   input  wire logic         flash_ready_i,
   // Pin drivers
   output logic              reset_in_pd_oe_n_o,
   output logic              reset_out_n_o,
   output logic              rpd_pulldown_o,
   output logic              io_hiz_o,
   output logic              address_latch_enable_o,
   output logic              read_strobe_n_o,
   output logic              write_strobe_n_o,
   // Status
   output logic              bidir_reset_enable_o,
   output logic              cancel_window_o,
   output logic              internal_reset_o,
   output logic              async_reset_o,
   output logic              short_reset_flag_o,
   output logic              long_reset_flag_o,
   output logic [2:0]        cfg_transparent_o,
   output logic [15:0]       sys_config_o,
   output logic [23:0]       fetch_addr_o
);
   import wsr_pkg::*;

   logic [1:0]  rin_sync_reg;
   logic [1:0]  filtered_reset_in_sync_reg;
   logic [1:0]  rpd_sync_reg;
   logic [1:0]  ea_sync_reg;
   logic [15:0] cfg_s1_reg;
   logic [15:0] cfg_s2_reg;
   logic        rin;
   logic        filtered_reset_in;
   logic        reset_power_down_pin;
   logic        ea;
   wsr_state_t  state_reg;
   wsr_state_t  state_next;
   logic [10:0] cnt_reg;
   logic [10:0] cnt_next;
   logic        sw_reg;
   logic        long_reg;
   logic        bdir_reg;
   logic        drive_reg;
   logic [1:0]  rel_cnt_reg;
   logic        in_reset;
   logic [10:0] seq_len_reg;

   // Two-stage synchronisers
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rin_sync_reg  <= 2'h3;
         filtered_reset_in_sync_reg <= 2'h3;
         rpd_sync_reg  <= 2'h3;
         ea_sync_reg   <= 2'h3;
         cfg_s1_reg    <= CFG_RESET;
         cfg_s2_reg    <= CFG_RESET;
      end
      else
      begin
         rin_sync_reg  <= {rin_sync_reg[0], reset_in_n_i};
         filtered_reset_in_sync_reg <= {filtered_reset_in_sync_reg[0], filtered_reset_in_i};
         rpd_sync_reg  <= {rpd_sync_reg[0], reset_power_down_pin_i};
         ea_sync_reg   <= {ea_sync_reg[0], external_access_sel_i};
         cfg_s1_reg    <= config_port_i;
         cfg_s2_reg    <= cfg_s1_reg;
      end
   end

   assign rin  = rin_sync_reg[1];
   assign filtered_reset_in = filtered_reset_in_sync_reg[1];
   assign reset_power_down_pin  = rpd_sync_reg[1];
   assign ea   = ea_sync_reg[1];
   assign in_reset = (state_reg != WSR_RUN) && (state_reg != WSR_ARM);

   // Sequence control
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      unique case (state_reg)
         WSR_RUN:
         begin
            if (software_reset_instr_i)
            begin
               state_next = WSR_CANCEL;                       // RQ20
               cnt_next   = CANCEL_CNT;
            end
            else if (!rin && reset_power_down_pin)
            begin
               state_next = WSR_ARM;                          // RQ1
               cnt_next   = ARM_CNT - CNT_ONE;
            end
         end
         WSR_ARM:
         begin
            if (rin)
               state_next = WSR_RUN;                          // RQ2
            else if (cnt_reg == CNT_ONE)
            begin
               state_next = WSR_CANCEL;
               cnt_next   = CANCEL_CNT;
            end
            else
               cnt_next = cnt_reg - CNT_ONE;
         end
         WSR_CANCEL:
         begin
            if (cnt_reg == CNT_ONE)
            begin
               state_next = WSR_SEQ;                          // RQ4 RQ7
               cnt_next   = SEQ_CNT;
            end
            else
               cnt_next = cnt_reg - CNT_ONE;
         end
         WSR_SEQ:
         begin
            if (cnt_reg == CNT_ONE)
            begin
               state_next = WSR_SAMPLE;                       // RQ7
               cnt_next   = SAMPLE_CNT;
            end
            else
               cnt_next = cnt_reg - CNT_ONE;
         end
         WSR_SAMPLE:
         begin
            if (cnt_reg == CNT_ONE)
               state_next = WSR_EXTEND;                       // RQ8
            else
               cnt_next = cnt_reg - CNT_ONE;
         end
         WSR_EXTEND:
         begin
            if (rin && (!ea || flash_ready_i))
               state_next = WSR_RUN;                          // RQ12
         end
         WSR_ASYNC:
         begin
            if (rin && (!ea || flash_ready_i))
               state_next = WSR_RUN;                          // RQ17
         end
         default:
            state_next = WSR_RUN;
      endcase
      // Hardware reset escalates while sense pin and filtered input are low
      if (in_reset && !sw_reg && !filtered_reset_in && !reset_power_down_pin && state_reg != WSR_ASYNC)
         state_next = WSR_ASYNC;                              // RQ16 RQ18 RQ19
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= WSR_RUN;
         cnt_reg   <= CNT_ZERO;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // Reset source
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         sw_reg <= 1'b0;
      else if (state_reg == WSR_RUN && state_next == WSR_CANCEL)
         sw_reg <= software_reset_instr_i;
      else if (state_next == WSR_RUN)
         sw_reg <= 1'b0;
   end

   // Bidirectional enable
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         bdir_reg <= 1'b0;                                    // RQ6
      else if (in_reset && state_next == WSR_RUN)
         bdir_reg <= 1'b0;                                    // RQ6
      else if (!in_reset && bidir_reset_set_i)
         bdir_reg <= 1'b1;
   end

   // Pin pull-down during sequence
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         drive_reg <= 1'b0;
      else if (state_next == WSR_CANCEL && state_reg != WSR_CANCEL)
         drive_reg <= bdir_reg && (!software_reset_instr_i || reset_power_down_pin); // RQ5 RQ22
      else if (state_next != WSR_CANCEL && state_next != WSR_SEQ)
         drive_reg <= 1'b0;                                   // RQ11
      else if (sw_reg && !reset_power_down_pin)
         drive_reg <= 1'b0;                                   // RQ22
   end

   // Short and long flags
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         short_reset_flag_o <= 1'b0;
         long_reset_flag_o  <= 1'b0;
         long_reg           <= 1'b0;
      end
      else
      begin
         if (state_reg == WSR_SAMPLE && cnt_reg == CNT_ONE)
         begin
            short_reset_flag_o <= 1'b1;                       // RQ8
            long_reset_flag_o  <= !filtered_reset_in && !sw_reg;           // RQ8 RQ20
            long_reg           <= !filtered_reset_in && !sw_reg;           // RQ9
         end
         else if (long_reg && filtered_reset_in && rel_cnt_reg == REL_MATCH)
            long_reg <= 1'b0;                                 // RQ10
         else if (state_reg == WSR_CANCEL && state_next == WSR_CANCEL
                  && cnt_reg == CANCEL_CNT)
         begin
            short_reset_flag_o <= 1'b0;
            long_reset_flag_o  <= 1'b0;
         end
      end
   end

   // Transparency release delay
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rel_cnt_reg <= 2'h0;
      else if (long_reg && filtered_reset_in)
         rel_cnt_reg <= rel_cnt_reg + 2'h1;
      else
         rel_cnt_reg <= 2'h0;
   end

   // Configuration latch and fetch address
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sys_config_o <= CFG_RESET;
         fetch_addr_o <= START_ADDR;
      end
      else if (in_reset && state_next == WSR_RUN)
      begin
         if (sw_reg)
            sys_config_o <= (sys_config_o & ~(SW_KEEP | SW_ONES))
                            | (cfg_s2_reg & SW_KEEP) | SW_ONES; // RQ21
         else
            sys_config_o <= cfg_s2_reg;                       // RQ13
         fetch_addr_o <= START_ADDR;                          // RQ14
      end
   end

   // Output registers
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         reset_out_n_o          <= 1'b1;
         io_hiz_o               <= 1'b0;
         rpd_pulldown_o         <= 1'b0;
         address_latch_enable_o <= 1'b0;
         read_strobe_n_o        <= 1'b1;
         write_strobe_n_o       <= 1'b1;
      end
      else
      begin
         reset_out_n_o          <= !(state_next != WSR_RUN && state_next != WSR_ARM); // RQ3
         io_hiz_o               <= state_next != WSR_RUN && state_next != WSR_ARM;    // RQ3
         rpd_pulldown_o         <= !rin || drive_reg;      // RQ15
         address_latch_enable_o <= 1'b0;                   // RQ13
         read_strobe_n_o        <= 1'b1;                   // RQ13
         write_strobe_n_o       <= 1'b1;                   // RQ13
      end
   end

   assign reset_in_pd_oe_n_o   = !drive_reg;                                // RQ11
   assign bidir_reset_enable_o = bdir_reg;
   assign cancel_window_o      = state_reg == WSR_CANCEL;                   // RQ4
   assign internal_reset_o     = in_reset;
   assign async_reset_o        = state_reg == WSR_ASYNC;
   assign cfg_transparent_o    = {3{long_reg}};                             // RQ9

   // Cycle count inside the internal sequence, for the length check
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         seq_len_reg <= CNT_ZERO;
      else if (state_reg == WSR_SEQ)
         seq_len_reg <= seq_len_reg + CNT_ONE;
      else
         seq_len_reg <= CNT_ZERO;
   end

   sequence s_seq_done;
      state_reg == WSR_SEQ && state_next == WSR_SAMPLE;
   endsequence

   a_seq_length: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ7
      $rose(state_reg == WSR_SEQ) |-> (state_reg == WSR_SEQ)[*8]);
   a_cancel_bound: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ4
      $rose(state_reg == WSR_CANCEL) |-> ##[1:12] state_reg != WSR_CANCEL);
   a_bdir_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ6
      (in_reset && state_next == WSR_RUN) |=> !bidir_reset_enable_o);
   a_out_low: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ3
      in_reset |-> !reset_out_n_o);
   a_pd_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ5
      !reset_in_pd_oe_n_o |-> in_reset);
   a_async_stays: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ17
      (state_reg == WSR_ASYNC && !rin) |=> state_reg == WSR_ASYNC);
   a_sw_no_long: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ20
      (sw_reg && state_reg == WSR_SAMPLE && cnt_reg == CNT_ONE) |=> !long_reset_flag_o);
   a_strobe_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ13
      read_strobe_n_o && write_strobe_n_o && !address_latch_enable_o);
   a_seq_exact: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ7
      s_seq_done |-> seq_len_reg == SEQ_CNT - CNT_ONE);
endmodule

// file: tb/wsr_reset_partner.sv
// Model of the external reset circuit sharing the reset pin
module wsr_reset_partner #(
   parameter int FILT_DLY = 3
) (
   // Clock
   input  wire logic clock_i,
   // Commands from the bench
   input  wire logic ext_low_i,
   input  wire logic rpd_drop_i,
   // Device pull-down on the reset pin
   input  wire logic reset_in_pd_oe_n_i,
   // Pin levels
   output logic      reset_in_n_o,
   output logic      filtered_reset_in_o,
   output logic      reset_power_down_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [FILT_DLY-1:0] filt_reg = '1;
   // Pull-up wins unless either party pulls low
   assign reset_in_n_o = ~(ext_low_i | ~reset_in_pd_oe_n_i);
   // Sense pin held up by its resistor unless discharged
   assign reset_power_down_pin_o = ~rpd_drop_i;
   // Filter delay on the way to the filtered input
   assign filtered_reset_in_o = filt_reg[FILT_DLY-1];
   always @(posedge clock_i)
      filt_reg <= {filt_reg[FILT_DLY-2:0], reset_in_n_o};
endmodule

// file: tb/tb.sv
// Self-checking bench of the warm and software reset sequencer
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import wsr_pkg::*;
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        ext_low = 1'b0;
   logic        rpd_drop = 1'b0;
   logic        ea_sel = 1'b0;
   logic [15:0] cfg_port = 16'hFFFF;
   logic        sw_reset = 1'b0;
   logic        bidir_set = 1'b0;
   logic        flash_ready = 1'b0;
   logic        rin_n, filt, rpd_pin, pd_oe_n, rout_n, rpd_pd, io_hiz, ale, rd_n, wr_n;
   logic        bidir_en, cancel_win, int_rst, async_rst, short_flag, long_flag;
   logic [2:0]  cfg_tr;
   logic [15:0] sys_cfg;
   logic [23:0] fetch;
   int          bad_count = 0;
   int          checked = 0;
   int          n;

   always #12.5 clock_i = ~clock_i;

   wsr_sequencer dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reset_in_n_i(rin_n),
      .filtered_reset_in_i(filt), .reset_power_down_pin_i(rpd_pin),
      .external_access_sel_i(ea_sel), .config_port_i(cfg_port),
      .software_reset_instr_i(sw_reset), .bidir_reset_set_i(bidir_set),
      .flash_ready_i(flash_ready), .reset_in_pd_oe_n_o(pd_oe_n), .reset_out_n_o(rout_n),
      .rpd_pulldown_o(rpd_pd), .io_hiz_o(io_hiz), .address_latch_enable_o(ale),
      .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .bidir_reset_enable_o(bidir_en),
      .cancel_window_o(cancel_win), .internal_reset_o(int_rst), .async_reset_o(async_rst),
      .short_reset_flag_o(short_flag), .long_reset_flag_o(long_flag),
      .cfg_transparent_o(cfg_tr), .sys_config_o(sys_cfg), .fetch_addr_o(fetch));

   wsr_reset_partner #(.FILT_DLY(3)) far_side (.clock_i(clock_i), .ext_low_i(ext_low),
      .rpd_drop_i(rpd_drop), .reset_in_pd_oe_n_i(pd_oe_n), .reset_in_n_o(rin_n),
      .filtered_reset_in_o(filt), .reset_power_down_pin_o(rpd_pin));

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return rout_n;
         1: return int_rst;
         2: return async_rst;
         3: return cancel_win;
         4: return pd_oe_n;
         5: return cfg_tr[2];
         default: return filt;
      endcase
   endfunction

   // Bounded wait for a watched signal to reach a level
   task automatic wait_until(input int sel, input logic val);
      for (int i = 0; i < 4000; i++)
      begin
         @(negedge clock_i);
         if (pick(sel) === val)
            return;
      end
      bad_count++;
      $display("ERROR t=%0t timeout sel=%h exp=%h", $time, sel, val);
      give_verdict();
   endtask

   // Cycles for which a watched signal keeps a level
   task automatic count_run(input int sel, input logic val, output int cnt);
      cnt = 0;
      while (pick(sel) === val && cnt < 5000)
      begin
         @(negedge clock_i);
         cnt++;
      end
      if (cnt >= 5000)
      begin
         bad_count++;
         $display("ERROR t=%0t count limit sel=%h exp=%h", $time, sel, val);
         give_verdict();
      end
   endtask

   task automatic pulse(input int sel);
      if (sel == 0)
         sw_reset = 1'b1;
      else
         bidir_set = 1'b1;
      @(negedge clock_i);
      sw_reset = 1'b0;
      bidir_set = 1'b0;
      @(negedge clock_i);
   endtask

   task automatic hw_low(input int cycles);
      ext_low = 1'b1;
      repeat (cycles) @(negedge clock_i);
      ext_low = 1'b0;
   endtask

   task automatic chk_exit(input logic [15:0] cfg, input logic lng);
      chk_bit(short_flag, 1'b1);
      chk_bit(long_flag, lng);
      chk_bit(bidir_en, 1'b0);
      chk_word(sys_cfg, cfg);
      chk_bit(ale, 1'b0);
      chk_bit(rd_n & wr_n, 1'b1);
      chk_word(fetch, START_ADDR);
   endtask

   initial
   begin
      repeat (5) @(negedge clock_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge clock_i);
      chk_bit(rout_n, 1'b1);
      chk_bit(pd_oe_n, 1'b1);
      chk_bit(bidir_en, 1'b0);
      chk_word(sys_cfg, CFG_RESET);
      // Pulse shorter than the arming time is refused
      hw_low(2);
      repeat (20) @(negedge clock_i);
      chk_bit(rout_n, 1'b1);
      chk_bit(int_rst, 1'b0);
      // Short hardware reset, bidirectional hold
      pulse(1);
      chk_bit(bidir_en, 1'b1);
      cfg_port = 16'hE5A7;
      ext_low = 1'b1;
      wait_until(4, 1'b0);
      chk_bit(rout_n, 1'b0);
      chk_bit(io_hiz, 1'b1);
      repeat (10) @(negedge clock_i);
      ext_low = 1'b0;
      chk_bit(rpd_pd, 1'b1);
      count_run(4, 1'b0, n);
      chk_word(24'(n), 24'(CANCEL_HALF + SEQ_HALF - 10));
      wait_until(1, 1'b0);
      chk_exit(16'hE5A7, 1'b0);
      // Long hardware reset with flash boot
      ea_sel = 1'b1;
      cfg_port = 16'h9A47;
      ext_low = 1'b1;
      wait_until(5, 1'b1);
      chk_word(cfg_tr, 24'h7);
      chk_bit(long_flag, 1'b1);
      chk_bit(int_rst, 1'b1);
      ext_low = 1'b0;
      wait_until(6, 1'b1);
      count_run(5, 1'b1, n);
      chk_bit(n >= RELEASE_HALF && n <= RELEASE_HALF + 1, 1'b1);
      repeat (20) @(negedge clock_i);
      chk_bit(int_rst, 1'b1);
      flash_ready = 1'b1;
      wait_until(1, 1'b0);
      chk_exit(16'h9A47, 1'b1);
      ea_sel = 1'b0;
      // Software reset, bidirectional with sense high
      pulse(1);
      cfg_port = 16'h3C13;
      pulse(0);
      chk_bit(rout_n, 1'b0);
      chk_bit(pd_oe_n, 1'b0);
      wait_until(1, 1'b0);
      chk_exit(16'h9CFF, 1'b0);
      // Software reset with sense low completes without pin drive
      pulse(1);
      rpd_drop = 1'b1;
      repeat (4) @(negedge clock_i);
      sw_reset = 1'b1;
      @(negedge clock_i);
      sw_reset = 1'b0;
      chk_bit(cancel_win, 1'b1);
      count_run(3, 1'b1, n);
      chk_word(24'(n), 24'(CANCEL_HALF));
      chk_bit(pd_oe_n, 1'b1);
      chk_bit(async_rst, 1'b0);
      wait_until(1, 1'b0);
      rpd_drop = 1'b0;
      // Escalation to asynchronous reset
      repeat (4) @(negedge clock_i);
      ext_low = 1'b1;
      wait_until(0, 1'b0);
      rpd_drop = 1'b1;
      wait_until(2, 1'b1);
      rpd_drop = 1'b0;
      repeat (8) @(negedge clock_i);
      chk_bit(async_rst, 1'b1);
      ext_low = 1'b0;
      wait_until(1, 1'b0);
      give_verdict();
   end
endmodule
